// file: rtl/bffr_regs.vh
/*
 * Constants of the boot flash fast-read controller: flash opcode,
 * signature location and bytes, boot source codes, strap reset value,
 * flash clock figures and shift counts.
 * Assumes inclusion by bare name from the rtl and testbench files.
 */
`ifndef BFFR_REGS_VH
`define BFFR_REGS_VH

`define BFFR_OP_FAST_READ  8'h0b
`define BFFR_SIG_ADDR      24'h00fffa
`define BFFR_BOOT_VECTOR   24'h000000
`define BFFR_SIG_B0        8'h32
`define BFFR_SIG_B1        8'h44
`define BFFR_SIG_B2        8'h46
`define BFFR_SIG_B3        8'h55
`define BFFR_SIG_LAST      2'h3
`define BFFR_DUMMY_BYTE    8'h00

`define BFFR_HDR_LAST      6'h27
`define BFFR_BYTE_LAST     6'h07

`define BFFR_SRC_NONE      2'h0
`define BFFR_SRC_FLASH     2'h1
`define BFFR_SRC_MGMT      2'h2
`define BFFR_SRC_INTERNAL  2'h3

`define BFFR_STRAP_DEFAULT 1'b0

`define BFFR_CORE_MHZ      10
`define BFFR_SLOW_MHZ      30
`define BFFR_FAST_MHZ      60
// core clock runs below either flash rate, so the flash clock is a divided
// core clock; the two settings keep the documented 1:2 ratio
`define BFFR_SLOW_HALF     4'h4
`define BFFR_FAST_HALF     4'h2

`endif

// file: rtl/bffr_sync.v
/*
 * Three-stage synchroniser for a pin level with a two-stage agreement
 * filter: the output changes only when stages two and three agree.
 * Assumes the pin is asynchronous to i_core_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module bffr_sync (
    input  wire i_core_clk,
    input  wire i_pin,
    output reg  o_level
);

    reg s1;
    reg s2;
    reg s3;

    // not reset: the chain must track the pin through reset so that
    // straps can be caught at the release
    always @(posedge i_core_clk) begin
        s1 <= i_pin;
        s2 <= s1;
        s3 <= s2;
        if (s2 == s3) begin
            o_level <= s3;
        end
    end

endmodule // bffr_sync

`default_nettype wire

// file: rtl/bffr_fifo.v
/*
 * Shift-register FIFO with valid/ready on both sides. Head entry and
 * its valid bit are flip-flops, so the drain side sees registered data.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none

module bffr_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 4
) (
    input  wire             i_core_clk,
    input  wire             i_srst,
    input  wire             i_in_valid,
    input  wire [WIDTH-1:0] i_in_data,
    output wire             o_in_ready,
    output wire             o_out_valid,
    output wire [WIDTH-1:0] o_out_data,
    input  wire             i_out_ready
);

    reg  [DEPTH-1:0]       v;
    reg  [WIDTH*DEPTH-1:0] qv;
    wire [DEPTH-1:0]       sv;
    wire [DEPTH-1:0]       below;
    wire [WIDTH*DEPTH-1:0] sq;
    wire                   pop;
    wire                   push;

    assign pop         = v[0] & i_out_ready;
    // full refuses a write even when a pop happens in the same cycle
    assign o_in_ready  = ~v[DEPTH-1];
    assign push        = i_in_valid & o_in_ready;
    assign o_out_valid = v[0];
    assign o_out_data  = qv[WIDTH-1:0];

    genvar g;
    generate
        for (g = 0; g < DEPTH; g = g + 1) begin : g_ent
            if (g == DEPTH - 1) begin : g_top
                assign sv[g] = pop ? 1'b0 : v[g];
                assign sq[g*WIDTH +: WIDTH] = qv[g*WIDTH +: WIDTH];
            end else begin : g_mid
                assign sv[g] = pop ? v[g+1] : v[g];
                assign sq[g*WIDTH +: WIDTH] = pop ? qv[(g+1)*WIDTH +: WIDTH]
                                                  : qv[g*WIDTH +: WIDTH];
            end
            if (g == 0) begin : g_first
                assign below[g] = 1'b1;
            end else begin : g_rest
                assign below[g] = sv[g-1];
            end
            always @(posedge i_core_clk) begin
                if (i_srst) begin
                    v[g] <= 1'b0;
                end else if (push && !sv[g] && below[g]) begin
                    v[g] <= 1'b1;
                    qv[g*WIDTH +: WIDTH] <= i_in_data;
                end else begin
                    v[g] <= sv[g];
                    qv[g*WIDTH +: WIDTH] <= sq[g*WIDTH +: WIDTH];
                end
            end
        end
    endgenerate

endmodule // bffr_fifo

`default_nettype wire

// file: rtl/bffr_ctrl.v
/*
 * Boot source selection, strap handling and automatic single-bit
 * fast-read engine serving processor code fetches from serial flash.
 * Assumes config inputs are on i_core_clk; strap, management-bus and
 * flash data pins are asynchronous and pass bffr_sync.
 */
// Behaviour
// - after reset probe the serial flash first; if present run entirely from it
// - only without flash check whether the management bus is present
// - with neither found run from internal defaults plus latched straps
// - management bus path enables configuration writes and one-time memory programming; only o_mgmt_cfg_en is raised here
// - strap pin driven in normal operation, high impedance during reset
// - strap level captured at reset release becomes the feature default
// - strap 0 selects slow 30 MHz flash clock (default), 1 selects 60 MHz; here half periods of 4 and 2 core cycles of 10 MHz give 1.25 and 2.5 MHz
// - in suspend strap pin floats if latched 1, driven low if latched 0
// - at power-up read signature 2DFU from flash address 0xFFFA
// - valid signature enables external ROM, execution from 0x0000; else internal
// - flash port enabled after reset; software disable bit turns it off
// - on code read drop chip select, send opcode 0x0B then 24-bit address
// - after address send one dummy byte, then eight clocks shift in data
// - after a full data byte return ready and that byte to the processor
// - next address equal previous plus one keeps select low, one more byte
// - non-sequential address raises chip select before starting a new read
// - vendor hub messages accepted by default after reset
// - works with flash in clock mode 0 or mode 3; here the flash clock always idles low, so only mode 0 framing is produced
`timescale 1ns/1ps
`default_nettype none
`include "bffr_regs.vh"

module bffr_ctrl #(
    parameter [3:0] SLOW_HALF = `BFFR_SLOW_HALF,
    parameter [3:0] FAST_HALF = `BFFR_FAST_HALF,
    parameter       FIFO_DEPTH = 4
) (
    input  wire        i_core_clk,
    input  wire        i_srst,
    input  wire        i_flash_port_disable,
    input  wire        i_suspend,
    input  wire        i_strap_func_out,
    input  wire        i_flash_speed_strap_in,
    output reg         o_flash_speed_strap_out,
    output reg         o_flash_speed_strap_oe_n,
    output reg         o_flash_speed_fast,
    input  wire        i_mgmt_bus_pullup,
    output reg  [1:0]  o_boot_src,
    output reg         o_boot_done,
    output reg         o_ext_rom_en,
    output reg         o_mgmt_cfg_en,
    output reg         o_vendor_hub_messages_en,
    input  wire        i_fetch_req,
    input  wire [23:0] i_fetch_addr,
    output reg         o_fetch_idle,
    output wire        o_fetch_valid,
    output wire [7:0]  o_fetch_data,
    input  wire        i_fetch_ready,
    output reg         o_flash_cs_n,
    output reg         o_flash_sclk,
    output reg         o_flash_mosi,
    input  wire        i_flash_miso
);

    localparam [1:0] B_STRAP = 2'h0;
    localparam [1:0] B_PROBE = 2'h1;
    localparam [1:0] B_MGMT  = 2'h2;
    localparam [1:0] B_RUN   = 2'h3;

    localparam [1:0] E_IDLE  = 2'h0;
    localparam [1:0] E_CMD   = 2'h1;
    localparam [1:0] E_DATA  = 2'h2;
    localparam [1:0] E_HOLD  = 2'h3;
    localparam [7:0] FR_OP   = `BFFR_OP_FAST_READ;

    reg  [1:0]  b_st;
    reg  [1:0]  eng;
    reg  [39:0] shreg;
    reg  [5:0]  bitcnt;
    reg  [3:0]  hc;
    reg  [7:0]  rx;
    reg         bdone;
    reg         samp;
    reg  [23:0] last_addr;
    reg         pend;
    reg  [23:0] pend_addr;
    reg  [1:0]  sig_idx;
    reg         sig_ok;
    reg         rst_d;
    reg         strap_latched;

    wire        strap_lvl;
    wire        mgmt_lvl;
    wire        miso_lvl;
    wire        fifo_in_ready;
    wire        fifo_in_valid;
    wire        take;
    wire        keep;
    wire        sig_match;
    wire [3:0]  half_m1;
    wire [23:0] seq_addr;

    function [7:0] sig_byte;
        input [1:0] idx;
        begin
            case (idx)
                2'h0:    sig_byte = `BFFR_SIG_B0;
                2'h1:    sig_byte = `BFFR_SIG_B1;
                2'h2:    sig_byte = `BFFR_SIG_B2;
                default: sig_byte = `BFFR_SIG_B3;
            endcase
        end
    endfunction

    bffr_sync u_sync_strap (
        .i_core_clk (i_core_clk),
        .i_pin      (i_flash_speed_strap_in),
        .o_level    (strap_lvl)
    );

    bffr_sync u_sync_mgmt (
        .i_core_clk (i_core_clk),
        .i_pin      (i_mgmt_bus_pullup),
        .o_level    (mgmt_lvl)
    );

    bffr_sync u_sync_miso (
        .i_core_clk (i_core_clk),
        .i_pin      (i_flash_miso),
        .o_level    (miso_lvl)
    );

    // fetched bytes wait here for the processor; a full queue stalls new fetches
    bffr_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_core_clk  (i_core_clk),
        .i_srst      (i_srst),
        .i_in_valid  (fifo_in_valid),
        .i_in_data   (rx),
        .o_in_ready  (fifo_in_ready),
        .o_out_valid (o_fetch_valid),
        .o_out_data  (o_fetch_data),
        .i_out_ready (i_fetch_ready)
    );

    assign fifo_in_valid = bdone & (b_st == B_RUN);
    assign take      = o_fetch_idle & i_fetch_req;
    assign keep      = !i_flash_port_disable && ((b_st == B_PROBE) || o_ext_rom_en);
    assign sig_match = (rx == sig_byte(sig_idx));
    assign half_m1   = o_flash_speed_fast ? (FAST_HALF - 4'h1) : (SLOW_HALF - 4'h1);
    assign seq_addr  = last_addr + 24'h000001;

    // strap pin, latched straps and default-on features
    always @(posedge i_core_clk) begin
        rst_d <= i_srst;
        if (i_srst) begin
            o_flash_speed_strap_oe_n <= 1'b1;
            o_flash_speed_strap_out  <= 1'b0;
            strap_latched            <= `BFFR_STRAP_DEFAULT;
            o_flash_speed_fast       <= `BFFR_STRAP_DEFAULT;
            o_vendor_hub_messages_en <= 1'b1;
        end else if (rst_d) begin
            strap_latched      <= strap_lvl;
            o_flash_speed_fast <= strap_lvl;
        end else if (i_suspend) begin
            o_flash_speed_strap_oe_n <= strap_latched;
            o_flash_speed_strap_out  <= 1'b0;
        end else begin
            o_flash_speed_strap_oe_n <= 1'b0;
            o_flash_speed_strap_out  <= i_strap_func_out;
        end
    end

    // boot sequencing, request capture and the flash shift engine
    always @(posedge i_core_clk) begin
        if (i_srst) begin
            b_st          <= B_STRAP;
            eng           <= E_IDLE;
            o_boot_src    <= `BFFR_SRC_NONE;
            o_boot_done   <= 1'b0;
            o_ext_rom_en  <= 1'b0;
            o_mgmt_cfg_en <= 1'b0;
            o_fetch_idle  <= 1'b0;
            o_flash_cs_n  <= 1'b1;
            o_flash_sclk  <= 1'b0;
            o_flash_mosi  <= 1'b0;
            shreg         <= 40'h0000000000;
            bitcnt        <= 6'h00;
            hc            <= 4'h0;
            rx            <= 8'h00;
            bdone         <= 1'b0;
            samp          <= 1'b0;
            last_addr     <= 24'h000000;
            pend          <= 1'b0;
            pend_addr     <= 24'h000000;
            sig_idx       <= 2'h0;
            sig_ok        <= 1'b0;
        end else begin
            bdone <= 1'b0;
            samp  <= 1'b0;
            case (b_st)
                B_STRAP: begin
                    if (i_flash_port_disable) begin
                        b_st <= B_MGMT;
                    end else begin
                        b_st      <= B_PROBE;
                        pend      <= 1'b1;
                        pend_addr <= `BFFR_SIG_ADDR;
                        sig_idx   <= 2'h0;
                        sig_ok    <= 1'b1;
                    end
                end
                B_PROBE: begin
                    if (i_flash_port_disable) begin
                        b_st <= B_MGMT;
                    end else if (bdone) begin
                        if (!sig_match) begin
                            sig_ok <= 1'b0;
                        end
                        if (sig_idx == `BFFR_SIG_LAST) begin
                            if (sig_ok && sig_match) begin
                                b_st         <= B_RUN;
                                o_boot_src   <= `BFFR_SRC_FLASH;
                                o_ext_rom_en <= 1'b1;
                                o_boot_done  <= 1'b1;
                            end else begin
                                b_st <= B_MGMT;
                            end
                        end else begin
                            sig_idx   <= sig_idx + 2'h1;
                            pend      <= 1'b1;
                            pend_addr <= seq_addr;
                        end
                    end
                end
                B_MGMT: begin
                    b_st          <= B_RUN;
                    o_boot_done   <= 1'b1;
                    o_mgmt_cfg_en <= mgmt_lvl;
                    o_boot_src    <= mgmt_lvl ? `BFFR_SRC_MGMT : `BFFR_SRC_INTERNAL;
                end
                B_RUN: begin
                    if (take) begin
                        pend      <= 1'b1;
                        pend_addr <= i_fetch_addr;
                    end
                end
                default: begin
                    b_st <= B_STRAP;
                end
            endcase

            case (eng)
                E_IDLE: begin
                    o_flash_cs_n <= 1'b1;
                    o_flash_sclk <= 1'b0;
                    if (pend && !i_flash_port_disable) begin
                        pend         <= 1'b0;
                        last_addr    <= pend_addr;
                        o_flash_cs_n <= 1'b0;
                        shreg        <= {`BFFR_OP_FAST_READ, pend_addr, `BFFR_DUMMY_BYTE};
                        o_flash_mosi <= FR_OP[7];
                        bitcnt       <= 6'h00;
                        hc           <= half_m1;
                        eng          <= E_CMD;
                    end
                end
                E_CMD, E_DATA: begin
                    if (hc != 4'h0) begin
                        hc <= hc - 4'h1;
                    end else begin
                        hc <= half_m1;
                        if (!o_flash_sclk) begin
                            o_flash_sclk <= 1'b1;
                        end else begin
                            // flash launches on this falling edge; its previous bit
                            // is taken one edge later, once the synchroniser shows it
                            o_flash_sclk <= 1'b0;
                            bitcnt       <= bitcnt + 6'h01;
                            if (eng == E_CMD) begin
                                shreg        <= {shreg[38:0], 1'b0};
                                o_flash_mosi <= shreg[38];
                                if (bitcnt == `BFFR_HDR_LAST) begin
                                    eng    <= E_DATA;
                                    bitcnt <= 6'h00;
                                end
                            end else begin
                                samp <= 1'b1;
                                if (bitcnt == `BFFR_BYTE_LAST) begin
                                    eng <= E_HOLD;
                                end
                            end
                        end
                    end
                end
                E_HOLD: begin
                    if (!keep) begin
                        o_flash_cs_n <= 1'b1;
                        eng          <= E_IDLE;
                    end else if (pend) begin
                        if (pend_addr == seq_addr) begin
                            pend      <= 1'b0;
                            last_addr <= pend_addr;
                            bitcnt    <= 6'h00;
                            hc        <= half_m1;
                            eng       <= E_DATA;
                        end else begin
                            o_flash_cs_n <= 1'b1;
                            eng          <= E_IDLE;
                        end
                    end
                end
                default: begin
                    eng <= E_IDLE;
                end
            endcase

            // the synchroniser trails the pin by four edges, a whole fast flash
            // period, so sampling on the fall itself would take a stale bit
            if (samp) begin
                rx    <= {rx[6:0], miso_lvl};
                bdone <= (eng == E_HOLD);
            end

            // one outstanding fetch at a time, and only with room in the queue
            o_fetch_idle <= (b_st == B_RUN) && o_ext_rom_en && !i_flash_port_disable &&
                            !take && !pend && !samp && !bdone && fifo_in_ready &&
                            ((eng == E_IDLE) || (eng == E_HOLD));
        end
    end

endmodule // bffr_ctrl

`default_nettype wire

// file: testbench/bffr_ctrl_properties.sv
/* checker: port-level timing and framing properties of bffr_ctrl.
   assumes it is bound to bffr_ctrl; one clock, synchronous reset. */
`timescale 1ns/1ps
`default_nettype none
`include "bffr_regs.vh"
module bffr_ctrl_properties #(
    parameter [3:0] SLOW_HALF = 4'h4,
    parameter [3:0] FAST_HALF = 4'h2
) (
    input wire logic        i_core_clk,
    input wire logic        i_srst,
    input wire logic        i_suspend,
    input wire logic        i_strap_func_out,
    input wire logic        o_flash_speed_strap_out,
    input wire logic        o_flash_speed_strap_oe_n,
    input wire logic        o_flash_speed_fast,
    input wire logic [1:0]  o_boot_src,
    input wire logic        o_boot_done,
    input wire logic        o_ext_rom_en,
    input wire logic        o_mgmt_cfg_en,
    input wire logic        o_vendor_hub_messages_en,
    input wire logic        i_fetch_req,
    input wire logic [23:0] i_fetch_addr,
    input wire logic        o_fetch_idle,
    input wire logic        o_fetch_valid,
    input wire logic [7:0]  o_fetch_data,
    input wire logic        i_fetch_ready,
    input wire logic        o_flash_cs_n,
    input wire logic        o_flash_sclk,
    input wire logic        o_flash_mosi
);
    logic [3:0]  run;
    logic [3:0]  nbit;
    logic [23:0] last;
    logic        seen;
    wire  [7:0]  op = `BFFR_OP_FAST_READ;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_srst);
    // run: cycles since the flash clock last moved; nbit: rises since select fell
    always @(posedge i_core_clk) begin
        run <= $changed(o_flash_sclk) ? 4'h1 : run + {3'h0, run != 4'hf};
        nbit <= o_flash_cs_n ? 4'h0 : nbit + {3'h0, $rose(o_flash_sclk) && nbit < 4'h8};
        if (i_srst)
            seen <= 1'b0;
        else if (o_fetch_idle && i_fetch_req)
            seen <= 1'b1;
        if (o_fetch_idle && i_fetch_req)
            last <= i_fetch_addr;
    end
    sequence s_take;
        o_fetch_idle && i_fetch_req;
    endsequence
    sequence s_fall;
        $fell(o_flash_sclk) && !o_flash_cs_n;
    endsequence
    reset_quiet_a: assert property (disable iff (1'b0) i_srst |=>
        o_flash_speed_strap_oe_n && o_flash_cs_n && !o_boot_done && o_vendor_hub_messages_en)
        else $error("outputs not quiet during reset");
    strap_drive_a: assert property ((!i_srst && !i_suspend) [*2] |=>
        !o_flash_speed_strap_oe_n && o_flash_speed_strap_out == $past(i_strap_func_out))
        else $error("strap pin not driven with its function");
    suspend_pin_a: assert property ((!i_srst && i_suspend) [*2] |=> o_flash_speed_fast ?
        o_flash_speed_strap_oe_n : !o_flash_speed_strap_oe_n && !o_flash_speed_strap_out)
        else $error("strap pin wrong in suspend");
    src_enable_a: assert property (o_boot_done |->
        o_ext_rom_en == (o_boot_src == `BFFR_SRC_FLASH) && o_mgmt_cfg_en == (o_boot_src == `BFFR_SRC_MGMT))
        else $error("enables disagree with boot source");
    fetch_gate_a: assert property (o_fetch_idle |-> o_boot_done && o_boot_src == `BFFR_SRC_FLASH)
        else $error("fetch offered without flash boot");
    take_busy_a: assert property (s_take |=> !o_fetch_idle)
        else $error("second request offered while busy");
    op_bits_a: assert property ($rose(o_flash_sclk) && !o_flash_cs_n && nbit < 4'h8 |->
        o_flash_mosi == op[3'h7 - nbit[2:0]])
        else $error("opcode bit wrong");
    sclk_idle_a: assert property (o_flash_cs_n |-> !o_flash_sclk)
        else $error("flash clock high while deselected");
    mosi_hold_a: assert property (o_flash_sclk && $past(o_flash_sclk) |-> $stable(o_flash_mosi))
        else $error("serial out moved while clock high");
    half_period_a: assert property (s_fall |-> run == (o_flash_speed_fast ? FAST_HALF : SLOW_HALF))
        else $error("flash clock high time wrong");
    byte_stands_a: assert property (o_fetch_valid && !i_fetch_ready |=>
        o_fetch_valid && $stable(o_fetch_data))
        else $error("fetched byte dropped before taken");
    seq_keep_a: assert property (s_take ##0 seen && !o_flash_cs_n && i_fetch_addr == last + 24'h1
        |=> !o_flash_cs_n [*8])
        else $error("select left on sequential fetch");
    nonseq_close_a: assert property (s_take ##0 seen && i_fetch_addr != last + 24'h1
        |-> ##[1:8] o_flash_cs_n)
        else $error("select not raised on jump");
endmodule // bffr_ctrl_properties
bind bffr_ctrl bffr_ctrl_properties #(.SLOW_HALF(SLOW_HALF), .FAST_HALF(FAST_HALF)) u_props (.*);
`default_nettype wire

// file: testbench/bffr_flash_model.sv
/* model: serial flash rom answering single-bit fast reads.
   assumes mode-0 framing from the controller; holds the boot signature
   unless told to corrupt it. */
`timescale 1ns/1ps
`default_nettype none
module bffr_flash_model (
    input  wire logic i_cs_n,
    input  wire logic i_sclk,
    input  wire logic i_mosi,
    input  wire logic i_sig_bad,
    output var  logic o_miso
);
    logic [31:0] hdr;
    logic [7:0]  op;
    logic [23:0] addr;
    logic [7:0]  sh;
    int          nrise;
    int          nfall;
    function automatic logic [7:0] rom(input logic [23:0] a);
        logic [31:0] sig;
        sig = i_sig_bad ? 32'h0 : 32'h32444655;
        if (a >= 24'h00fffa && a <= 24'h00fffd)
            return sig[8 * (24'h00fffd - a) +: 8];
        return a[7:0] ^ a[15:8] ^ 8'h5a;
    endfunction
    initial o_miso = 1'b0;
    always @(negedge i_cs_n) begin
        nrise = 0;
        nfall = 0;
    end
    // take bits on the rise, most significant first
    always @(posedge i_sclk) if (!i_cs_n) begin
        hdr = {hdr[30:0], i_mosi};
        nrise = nrise + 1;
        if (nrise == 32) begin
            op = hdr[31:24];
            addr = hdr[23:0];
        end
    end
    // first data bit leaves on the fall that ends the dummy byte; streams on
    always @(negedge i_sclk) if (!i_cs_n) begin
        nfall = nfall + 1;
        if (nfall >= 40) begin
            if ((nfall - 40) % 8 == 0)
                sh = rom(addr + 24'((nfall - 40) / 8));
            o_miso = sh[7 - (nfall - 40) % 8];
        end
    end
    // no pull on this line: once released it shows the opposite of its last bit
    always @(posedge i_cs_n) o_miso = ~o_miso;
endmodule // bffr_flash_model
`default_nettype wire

// file: testbench/bffr_ctrl_tb.sv
/* bench: boots the controller five ways and streams code fetches from
   the flash model. assumes default half periods and a 100 ns core clock. */
`timescale 1ns/1ps
`default_nettype none
module bffr_ctrl_tb;
    logic        i_core_clk = 1'b0;
    logic        i_srst = 1'b1;
    logic        i_flash_port_disable = 1'b0;
    logic        i_suspend = 1'b0;
    logic        i_strap_func_out = 1'b0;
    logic        i_mgmt_bus_pullup = 1'b0;
    logic        i_fetch_req = 1'b0;
    logic [23:0] i_fetch_addr = 24'h0;
    logic        i_fetch_ready = 1'b0;
    logic        strap_bias = 1'b0;
    logic        sig_bad = 1'b0;
    logic [31:0] lfsr = 32'h8e58;
    int          mismatches = 0;
    int          total_checks = 0;
    wire         o_flash_speed_strap_out, o_flash_speed_strap_oe_n, o_flash_speed_fast;
    wire         o_boot_done, o_ext_rom_en, o_mgmt_cfg_en, o_vendor_hub_messages_en;
    wire         o_fetch_idle, o_fetch_valid, o_flash_cs_n, o_flash_sclk, o_flash_mosi;
    wire         i_flash_miso;
    wire [1:0]   o_boot_src;
    wire [7:0]   o_fetch_data;
    // the board only biases the strap through a resistor
    wire i_flash_speed_strap_in = o_flash_speed_strap_oe_n ? strap_bias : o_flash_speed_strap_out;
    // {strap, bad signature, bus pull-up, port disable, expected source}
    logic [5:0]  cases [5] = '{6'b001001, 6'b111010, 6'b010011, 6'b001110, 6'b100001};
    bffr_ctrl dut (.*);
    bffr_flash_model fm (.i_cs_n(o_flash_cs_n), .i_sclk(o_flash_sclk), .i_mosi(o_flash_mosi),
        .i_sig_bad(sig_bad), .o_miso(i_flash_miso));
    always #50 i_core_clk = ~i_core_clk;
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic logic [7:0] exp_byte(input logic [23:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5a;
    endfunction
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // every wait is bounded; running out ends the run as a failure
    task automatic step(inout int n);
        @(negedge i_core_clk);
        n++;
        if (n > 4000) begin
            mismatches++;
            $display("BAD wait expected below 4000 seen %0d", n);
            end_sim();
        end
    endtask
    task automatic fetch(input logic [23:0] a);
        int n = 0;
        do step(n); while (o_fetch_idle !== 1'b1);
        @(posedge i_core_clk);
        i_fetch_req <= 1'b1;
        i_fetch_addr <= a;
        @(posedge i_core_clk);
        i_fetch_req <= 1'b0;
        // busy only shows one edge after the take
        @(posedge i_core_clk);
    endtask
    task automatic pop(input logic [23:0] a);
        int n = 0;
        do step(n); while (o_fetch_valid !== 1'b1);
        check("fetch_data", o_fetch_data, exp_byte(a));
        @(posedge i_core_clk);
        i_fetch_ready <= 1'b1;
        @(posedge i_core_clk);
        i_fetch_ready <= 1'b0;
    endtask
    task automatic boot(input logic [5:0] c);
        logic [23:0] a;
        int n = 0;
        @(posedge i_core_clk);
        i_srst <= 1'b1;
        {strap_bias, sig_bad, i_mgmt_bus_pullup, i_flash_port_disable} <= c[5:2];
        i_strap_func_out <= lfsr[0];
        repeat (10) @(negedge i_core_clk);
        check("reset_outs", {o_flash_speed_strap_oe_n, o_flash_cs_n, o_boot_done}, 3'b110);
        check("hub_msgs", o_vendor_hub_messages_en, 1'b1);
        @(posedge i_core_clk);
        i_srst <= 1'b0;
        do step(n); while (o_boot_done !== 1'b1);
        check("boot_src", o_boot_src, c[1:0]);
        check("ext_rom", o_ext_rom_en, c[1:0] == 2'h1);
        check("mgmt_cfg", o_mgmt_cfg_en, c[1:0] == 2'h2);
        check("speed", o_flash_speed_fast, c[5]);
        check("strap_drv", {o_flash_speed_strap_oe_n, o_flash_speed_strap_out}, {1'b0, lfsr[0]});
        @(posedge i_core_clk);
        i_suspend <= 1'b1;
        repeat (3) @(negedge i_core_clk);
        check("suspend_pin", {o_flash_speed_strap_oe_n, i_flash_speed_strap_in}, {2{c[5]}});
        @(posedge i_core_clk);
        i_suspend <= 1'b0;
        if (c[1:0] != 2'h1) begin
            check("no_fetch", o_fetch_idle, 1'b0);
            return;
        end
        fetch(24'h000000);
        pop(24'h000000);
        check("opcode", fm.op, 8'h0b);
        check("start_addr", fm.addr, 24'h000000);
        repeat (3) begin
            lfsr = nxt(lfsr);
            // kept clear of the signature bytes
            a = lfsr[23:0] | 24'h100000;
            for (int i = 0; i < 4; i++) fetch(a + 24'(i));
            repeat (100) @(negedge i_core_clk);
            check("full_refused", o_fetch_idle, 1'b0);
            for (int i = 0; i < 4; i++) pop(a + 24'(i));
            check("reopen_addr", fm.addr, a);
            @(negedge i_core_clk);
            check("drained", o_fetch_valid, 1'b0);
        end
    endtask
    initial begin
        foreach (cases[k]) begin
            lfsr = nxt(lfsr);
            boot(cases[k]);
        end
        end_sim();
    end
endmodule // bffr_ctrl_tb
`default_nettype wire
